// file: wdt_wake_pkg.sv
// constants, types and helpers shared by the watchdog and wake-up block
package wdt_wake_pkg;

    localparam int ADDR_W  = 3;
    localparam int DATA_W  = 8;
    localparam int PORTA_W = 8;
    localparam int INT_W   = 8;
    localparam int CNT_W   = 18;

    // register offsets
    localparam logic [ADDR_W-1:0] OFS_WDT_CTRL = 3'h0;
    localparam logic [ADDR_W-1:0] OFS_SYS_CTRL = 3'h1;
    localparam logic [ADDR_W-1:0] OFS_SYS_MODE = 3'h2;
    localparam logic [ADDR_W-1:0] OFS_STATUS   = 3'h3;
    localparam logic [ADDR_W-1:0] OFS_PA_WAKE  = 3'h4;

    // field positions
    localparam int WDT_KEY_LSB        = 3;
    localparam int WDT_KEY_MSB        = 7;
    localparam int WDT_PER_LSB        = 0;
    localparam int WDT_PER_MSB        = 2;
    localparam int SYS_IDLE_KEEP_BIT  = 7;
    localparam int SYS_UV_FLAG_BIT    = 2;
    localparam int SYS_VS_FLAG_BIT    = 1;
    localparam int SYS_KEY_FLAG_BIT   = 0;
    localparam int MODE_IDLE_SEL_BIT  = 0;
    localparam int STATUS_PDF_BIT     = 0;
    localparam int STATUS_TO_BIT      = 1;

    // reset values
    localparam logic [DATA_W-1:0]  WDT_CTRL_RST = 8'h53;
    localparam logic [DATA_W-1:0]  SYS_CTRL_RST = 8'h00;
    localparam logic [DATA_W-1:0]  SYS_MODE_RST = 8'h00;
    localparam logic [PORTA_W-1:0] PA_WAKE_RST  = 8'h00;

    // key codes
    localparam logic [4:0] KEY_DISABLE = 5'h15;
    localparam logic [4:0] KEY_ENABLE  = 5'h0a;

    // timing: the watchdog runs from the low-speed rc oscillator
    localparam int         LOW_SPEED_RC_OSC_NOMINAL_KHZ   = 32;
    localparam int         KEY_RESET_MIN_LOW_SPEED_RC_OSC = 2;
    localparam logic [1:0] KEY_RESET_TICKS    = 2'(KEY_RESET_MIN_LOW_SPEED_RC_OSC + 1);

    typedef enum logic [1:0] {
        mode_run,
        mode_idle_clk,
        mode_low
    } mode_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic              wr;
        logic              rd;
    } reg_req_t;

    typedef struct packed {
        logic halt;
        logic clear_watchdog_instruction;
    } cpu_event_t;

    typedef struct packed {
        logic wake;
        logic resume_next;
        logic int_response;
        logic system_reset;
        logic pc_sp_reset;
    } wake_out_t;

    typedef struct packed {
        logic sys_clk_en;
        logic timebase_clk_en;
        logic sub_clk_en;
        logic cpu_halted;
    } clk_ctl_t;

    // terminal count for a period code: 2^n - 1 watchdog clocks
    function automatic logic [CNT_W-1:0] period_mask(input logic [2:0] sel);
        logic [CNT_W-1:0] m;
        m = '0;
        unique case (sel)
            3'h0: m = 18'h000ff;
            3'h1: m = 18'h003ff;
            3'h2: m = 18'h00fff;
            3'h3: m = 18'h03fff;
            3'h4: m = 18'h07fff;
            3'h5: m = 18'h0ffff;
            3'h6: m = 18'h1ffff;
            3'h7: m = 18'h3ffff;
        endcase
        return m;
    endfunction : period_mask

endpackage : wdt_wake_pkg

// file: watchdog_and_wakeup_control.sv
// watchdog timer, power-down entry and wake-up control
// Operation
// - halt with idle select and clock keep both set enters idle-with-clock mode
// - entering idle keeps state; watchdog counter cleared, resumes if enabled
// - halt sets the power-down flag and clears the timeout flag
// - low-power modes wake on reset, port A fall, interrupt or overflow
// - reset wake is full reset; overflow wake sets timeout, resets pc and sp
// - power-down flag cleared by power-up or clear-watchdog, set by halt
// - per-pin port A wake enables; resume after the halt
// - disabled or stack-full interrupt wake resumes after halt, stays pending
// - enabled interrupt with free stack gets normal interrupt response
// - requests already pending at halt do not wake the device
// - watchdog counter is clocked by the low-speed rc oscillator
// - period code selects 2^8,10,12,14,15,16,17,18 watchdog clocks
// - always-enabled option: both keys keep running, others reset
// - software option: 10101 disables, 01010 enables, others reset
// - bad key resets after 2 to 3 oscillator cycles, sets key flag
// - key flag set only by hardware, cleared only by writing zero
// - system control bits 6 to 3 read as zero
// - timeout resets device when running, only pc and sp when asleep
// - clear-watchdog instruction, reset or halt clear the counter
//
// Chosen here: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none

module watchdog_and_wakeup_control (
    // clock and reset
    input  wire logic                             clk,
    input  wire logic                             resetn,
    // register port
    input  wire wdt_wake_pkg::reg_req_t           reg_req,
    output logic [wdt_wake_pkg::DATA_W-1:0]       reg_rdata,
    // core side
    input  wire wdt_wake_pkg::cpu_event_t         cpu_event,
    input  wire logic                             wdt_always_on,
    input  wire logic [wdt_wake_pkg::INT_W-1:0]   int_req,
    input  wire logic [wdt_wake_pkg::INT_W-1:0]   int_enable,
    input  wire logic                             stack_full,
    // pins
    input  wire logic                             low_speed_rc_osc_clk,
    input  wire logic [wdt_wake_pkg::PORTA_W-1:0] porta_pins,
    // results
    output wdt_wake_pkg::wake_out_t               wake_out,
    output wdt_wake_pkg::clk_ctl_t                clk_ctl,
    output logic                                  wdt_running
);

    typedef struct packed {
        wdt_wake_pkg::mode_t                    mode;
        logic [wdt_wake_pkg::DATA_W-1:0]        wdt_ctrl;
        logic                                   idle_clock_keep;
        logic                                   undervoltage_reset_flag;
        logic                                   voltage_select_reset_flag;
        logic                                   key_reset_flag;
        logic                                   idle_select;
        logic                                   powerdown_flag;
        logic                                   timeout_flag;
        logic [wdt_wake_pkg::PORTA_W-1:0]       porta_wake_enable;
        logic [wdt_wake_pkg::CNT_W-1:0]         cnt;
        logic [2:0]                             period;
        logic [1:0]                             key_cnt;
        logic                                   low_speed_rc_osc_meta;
        logic                                   low_speed_rc_osc_sync;
        logic                                   low_speed_rc_osc_prev;
        logic [wdt_wake_pkg::PORTA_W-1:0]       pa_meta;
        logic [wdt_wake_pkg::PORTA_W-1:0]       pa_sync;
        logic [wdt_wake_pkg::PORTA_W-1:0]       pa_prev;
        logic [wdt_wake_pkg::INT_W-1:0]         int_masked;
        logic [wdt_wake_pkg::DATA_W-1:0]        rdata;
        wdt_wake_pkg::wake_out_t                pulses;
    } state_t;

    state_t s_q;
    state_t s_d;

    logic                              low_speed_rc_osc_tick;
    logic [4:0]                        key;
    logic                              key_ok;
    logic                              wdt_on;
    logic                              overflow;
    logic [wdt_wake_pkg::PORTA_W-1:0]  pa_fall;
    logic [wdt_wake_pkg::INT_W-1:0]    int_new;
    logic [wdt_wake_pkg::INT_W-1:0]    int_serve;
    logic [wdt_wake_pkg::DATA_W-1:0]   sys_ctrl_rd;

    always_comb begin
        s_d         = s_q;
        s_d.pulses  = '0;
        s_d.rdata   = '0;

        // pin synchronisers; the first stage feeds only the second
        s_d.low_speed_rc_osc_meta = low_speed_rc_osc_clk;
        s_d.low_speed_rc_osc_sync = s_q.low_speed_rc_osc_meta;
        s_d.low_speed_rc_osc_prev = s_q.low_speed_rc_osc_sync;
        s_d.pa_meta   = porta_pins;
        s_d.pa_sync   = s_q.pa_meta;
        s_d.pa_prev   = s_q.pa_sync;

        // one enable pulse per oscillator rising edge
        low_speed_rc_osc_tick = s_q.low_speed_rc_osc_sync & ~s_q.low_speed_rc_osc_prev;

        key    = s_q.wdt_ctrl[wdt_wake_pkg::WDT_KEY_MSB:wdt_wake_pkg::WDT_KEY_LSB];
        key_ok = (key == wdt_wake_pkg::KEY_DISABLE) || (key == wdt_wake_pkg::KEY_ENABLE);
        wdt_on = key_ok && (wdt_always_on || key == wdt_wake_pkg::KEY_ENABLE);

        // the latched code is used so a rewrite cannot cut a running sequence short
        overflow = wdt_on && low_speed_rc_osc_tick && (s_q.cnt == wdt_wake_pkg::period_mask(s_q.period));

        pa_fall   = s_q.pa_prev & ~s_q.pa_sync & s_q.porta_wake_enable;
        int_new   = int_req & ~s_q.int_masked;
        int_serve = int_new & int_enable;

        sys_ctrl_rd = '0;
        sys_ctrl_rd[wdt_wake_pkg::SYS_IDLE_KEEP_BIT] = s_q.idle_clock_keep;
        sys_ctrl_rd[wdt_wake_pkg::SYS_UV_FLAG_BIT]   = s_q.undervoltage_reset_flag;
        sys_ctrl_rd[wdt_wake_pkg::SYS_VS_FLAG_BIT]   = s_q.voltage_select_reset_flag;
        sys_ctrl_rd[wdt_wake_pkg::SYS_KEY_FLAG_BIT]  = s_q.key_reset_flag;

        // register reads, answered in the next cycle
        if (reg_req.rd) begin
            unique case (reg_req.addr)
                wdt_wake_pkg::OFS_WDT_CTRL: s_d.rdata = s_q.wdt_ctrl;
                wdt_wake_pkg::OFS_SYS_CTRL: s_d.rdata = sys_ctrl_rd;
                wdt_wake_pkg::OFS_SYS_MODE: s_d.rdata[wdt_wake_pkg::MODE_IDLE_SEL_BIT] = s_q.idle_select;
                wdt_wake_pkg::OFS_STATUS: begin
                    s_d.rdata[wdt_wake_pkg::STATUS_PDF_BIT] = s_q.powerdown_flag;
                    s_d.rdata[wdt_wake_pkg::STATUS_TO_BIT]  = s_q.timeout_flag;
                end
                wdt_wake_pkg::OFS_PA_WAKE:  s_d.rdata = s_q.porta_wake_enable;
                default:                    s_d.rdata = '0;
            endcase
        end

        // register writes; hardware events below override them
        if (reg_req.wr) begin
            unique case (reg_req.addr)
                wdt_wake_pkg::OFS_WDT_CTRL: s_d.wdt_ctrl = reg_req.wdata;
                wdt_wake_pkg::OFS_SYS_CTRL: begin
                    s_d.idle_clock_keep           = reg_req.wdata[wdt_wake_pkg::SYS_IDLE_KEEP_BIT];
                    s_d.undervoltage_reset_flag   = reg_req.wdata[wdt_wake_pkg::SYS_UV_FLAG_BIT];
                    s_d.voltage_select_reset_flag = reg_req.wdata[wdt_wake_pkg::SYS_VS_FLAG_BIT];
                    // writing one leaves the flag alone
                    if (!reg_req.wdata[wdt_wake_pkg::SYS_KEY_FLAG_BIT]) begin
                        s_d.key_reset_flag = 1'b0;
                    end
                end
                wdt_wake_pkg::OFS_SYS_MODE: s_d.idle_select = reg_req.wdata[wdt_wake_pkg::MODE_IDLE_SEL_BIT];
                wdt_wake_pkg::OFS_PA_WAKE:  s_d.porta_wake_enable = reg_req.wdata;
                default: begin
                end
            endcase
        end

        // counter runs on oscillator ticks only; held clear while disabled
        if (!wdt_on) begin
            s_d.cnt    = '0;
            s_d.period = s_q.wdt_ctrl[wdt_wake_pkg::WDT_PER_MSB:wdt_wake_pkg::WDT_PER_LSB];
        end else if (low_speed_rc_osc_tick) begin
            s_d.cnt = s_q.cnt + 1'b1;
        end

        if (cpu_event.clear_watchdog_instruction) begin
            s_d.cnt            = '0;
            s_d.period         = s_q.wdt_ctrl[wdt_wake_pkg::WDT_PER_MSB:wdt_wake_pkg::WDT_PER_LSB];
            s_d.powerdown_flag = 1'b0;
        end

        // halt only acts while the core is executing
        if (cpu_event.halt && s_q.mode == wdt_wake_pkg::mode_run) begin
            s_d.cnt            = '0;
            s_d.period         = s_q.wdt_ctrl[wdt_wake_pkg::WDT_PER_MSB:wdt_wake_pkg::WDT_PER_LSB];
            s_d.powerdown_flag = 1'b1;
            s_d.timeout_flag   = 1'b0;
            s_d.int_masked     = int_req;
            if (s_q.idle_select && s_q.idle_clock_keep) begin
                s_d.mode = wdt_wake_pkg::mode_idle_clk;
            end else begin
                s_d.mode = wdt_wake_pkg::mode_low;
            end
        end

        // wake sources while halted
        if (s_q.mode != wdt_wake_pkg::mode_run && !overflow) begin
            if (int_new != '0) begin
                s_d.mode        = wdt_wake_pkg::mode_run;
                s_d.pulses.wake = 1'b1;
                s_d.int_masked  = '0;
                if (int_serve != '0 && !stack_full) begin
                    s_d.pulses.int_response = 1'b1;
                end else begin
                    s_d.pulses.resume_next = 1'b1;
                end
            end else if (pa_fall != '0) begin
                s_d.mode               = wdt_wake_pkg::mode_run;
                s_d.pulses.wake        = 1'b1;
                s_d.pulses.resume_next = 1'b1;
                s_d.int_masked         = '0;
            end
        end

        // overflow: full reset when running, pc and sp only when halted
        if (overflow) begin
            s_d.cnt          = '0;
            s_d.period       = s_q.wdt_ctrl[wdt_wake_pkg::WDT_PER_MSB:wdt_wake_pkg::WDT_PER_LSB];
            s_d.timeout_flag = 1'b1;
            s_d.int_masked   = '0;
            if (s_q.mode == wdt_wake_pkg::mode_run) begin
                s_d.pulses.system_reset = 1'b1;
            end else begin
                s_d.mode               = wdt_wake_pkg::mode_run;
                s_d.pulses.wake        = 1'b1;
                s_d.pulses.pc_sp_reset = 1'b1;
            end
        end

        // corrupted key: reset after the third tick, i.e. 2 to 3 oscillator cycles
        if (key_ok) begin
            s_d.key_cnt = '0;
        end else if (low_speed_rc_osc_tick) begin
            if (s_q.key_cnt == wdt_wake_pkg::KEY_RESET_TICKS - 2'h1) begin
                s_d.key_cnt             = '0;
                s_d.key_reset_flag      = 1'b1;
                s_d.pulses.system_reset = 1'b1;
                s_d.pulses.wake         = (s_q.mode != wdt_wake_pkg::mode_run);
                s_d.pulses.pc_sp_reset  = 1'b0;
                s_d.pulses.resume_next  = 1'b0;
                s_d.pulses.int_response = 1'b0;
                s_d.wdt_ctrl            = wdt_wake_pkg::WDT_CTRL_RST;
                s_d.cnt                 = '0;
                s_d.period              = wdt_wake_pkg::WDT_CTRL_RST[wdt_wake_pkg::WDT_PER_MSB:wdt_wake_pkg::WDT_PER_LSB];
                s_d.mode                = wdt_wake_pkg::mode_run;
                s_d.int_masked          = '0;
            end else begin
                s_d.key_cnt = s_q.key_cnt + 2'h1;
            end
        end
    end

    // external reset is the full reset: power-up state everywhere
    always_ff @(posedge clk) begin
        if (!resetn) begin
            s_q                           <= '0;
            s_q.mode                      <= wdt_wake_pkg::mode_run;
            s_q.wdt_ctrl                  <= wdt_wake_pkg::WDT_CTRL_RST;
            s_q.period                    <= wdt_wake_pkg::WDT_CTRL_RST[wdt_wake_pkg::WDT_PER_MSB:wdt_wake_pkg::WDT_PER_LSB];
            s_q.idle_clock_keep           <= wdt_wake_pkg::SYS_CTRL_RST[wdt_wake_pkg::SYS_IDLE_KEEP_BIT];
            s_q.undervoltage_reset_flag   <= wdt_wake_pkg::SYS_CTRL_RST[wdt_wake_pkg::SYS_UV_FLAG_BIT];
            s_q.voltage_select_reset_flag <= wdt_wake_pkg::SYS_CTRL_RST[wdt_wake_pkg::SYS_VS_FLAG_BIT];
            s_q.key_reset_flag            <= wdt_wake_pkg::SYS_CTRL_RST[wdt_wake_pkg::SYS_KEY_FLAG_BIT];
            s_q.idle_select               <= wdt_wake_pkg::SYS_MODE_RST[wdt_wake_pkg::MODE_IDLE_SEL_BIT];
            s_q.porta_wake_enable         <= wdt_wake_pkg::PA_WAKE_RST;
        end else begin
            s_q <= s_d;
        end
    end

    // clocks: all kept in idle-with-clock, stopped in the other low-power modes
    always_comb begin
        clk_ctl.cpu_halted      = (s_q.mode != wdt_wake_pkg::mode_run);
        clk_ctl.sys_clk_en      = (s_q.mode != wdt_wake_pkg::mode_low);
        clk_ctl.timebase_clk_en = (s_q.mode != wdt_wake_pkg::mode_low);
        clk_ctl.sub_clk_en      = (s_q.mode != wdt_wake_pkg::mode_low);
    end

    assign reg_rdata   = s_q.rdata;
    assign wake_out    = s_q.pulses;
    assign wdt_running = wdt_on;

endmodule : watchdog_and_wakeup_control

`default_nettype wire

// file: watchdog_and_wakeup_control_assertions.sv
// port-level checks for the watchdog and wake-up block, bound to its top module
`timescale 1ns/1ps
`default_nettype none

module watchdog_and_wakeup_control_checker (
    // clock and reset
    input wire logic                            clk,
    input wire logic                            resetn,
    // register port, core events and options
    input wire wdt_wake_pkg::reg_req_t          reg_req,
    input wire logic [wdt_wake_pkg::DATA_W-1:0] reg_rdata,
    input wire wdt_wake_pkg::cpu_event_t        cpu_event,
    input wire logic                            wdt_always_on,
    // results
    input wire wdt_wake_pkg::wake_out_t         wake_out,
    input wire wdt_wake_pkg::clk_ctl_t          clk_ctl,
    input wire logic                            wdt_running
);
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);

    logic key_wr;
    logic bad_key;
    assign key_wr  = reg_req.wr && reg_req.addr == wdt_wake_pkg::OFS_WDT_CTRL;
    assign bad_key = key_wr && reg_req.wdata[7:3] != wdt_wake_pkg::KEY_DISABLE
                     && reg_req.wdata[7:3] != wdt_wake_pkg::KEY_ENABLE;

    halt_enter_a: assert property (cpu_event.halt && !clk_ctl.cpu_halted |=> clk_ctl.cpu_halted)
        else $error("halt did not stop the core");
    clk_group_a: assert property (clk_ctl.timebase_clk_en == clk_ctl.sys_clk_en
                                  && clk_ctl.sub_clk_en == clk_ctl.sys_clk_en)
        else $error("clock enables disagree");
    run_clocks_a: assert property (!clk_ctl.cpu_halted |-> clk_ctl.sys_clk_en)
        else $error("clock off while running");
    wake_leave_a: assert property (wake_out.wake |-> $past(clk_ctl.cpu_halted) && !clk_ctl.cpu_halted)
        else $error("wake pulse without leaving halt");
    pulse_short_a: assert property (wake_out != '0 |=> wake_out == '0)
        else $error("result pulse longer than one cycle");
    wake_kind_a: assert property (wake_out.wake |->
        $onehot({wake_out.resume_next, wake_out.int_response, wake_out.pc_sp_reset, wake_out.system_reset}))
        else $error("wake pulse without exactly one kind");
    sleep_ovf_a: assert property (wake_out.pc_sp_reset |-> wake_out.wake && !wake_out.system_reset)
        else $error("pc and sp reset outside a wake");
    run_reset_a: assert property (wake_out.system_reset && !wake_out.wake |-> !$past(clk_ctl.cpu_halted))
        else $error("reset without wake while halted");
    key_effect_a: assert property (key_wr && reg_req.wdata[7:3] == wdt_wake_pkg::KEY_DISABLE
                                   |=> wdt_running == wdt_always_on)
        else $error("disable key handled wrongly");
    key_delay_a: assert property (bad_key |=> !wake_out.system_reset [*3] ##[1:400] wake_out.system_reset)
        else $error("bad key reset timing wrong");
    ctrl_unused_a: assert property (reg_req.rd && reg_req.addr == wdt_wake_pkg::OFS_SYS_CTRL
                                    |=> reg_rdata[6:3] == 4'h0)
        else $error("unused control bits not zero");

endmodule : watchdog_and_wakeup_control_checker

bind watchdog_and_wakeup_control watchdog_and_wakeup_control_checker u_checker (
    .clk(clk), .resetn(resetn), .reg_req(reg_req), .reg_rdata(reg_rdata), .cpu_event(cpu_event),
    .wdt_always_on(wdt_always_on), .wake_out(wake_out), .clk_ctl(clk_ctl), .wdt_running(wdt_running)
);

`default_nettype wire

// file: watchdog_and_wakeup_control_test.sv
// self-checking bench for the watchdog and wake-up block
`timescale 1ns/1ps
`default_nettype none

module watchdog_and_wakeup_control_test;
    logic                     clk           = 1'b0;
    logic                     resetn        = 1'b0;
    wdt_wake_pkg::reg_req_t   reg_req       = '0;
    logic [7:0]               reg_rdata;
    wdt_wake_pkg::cpu_event_t cpu_event     = '0;
    logic                     wdt_always_on = 1'b0;
    logic [7:0]               int_req       = 8'h00;
    logic [7:0]               int_enable    = 8'h00;
    logic                     stack_full    = 1'b0;
    logic                     low_speed_rc_osc_clk      = 1'b0;
    logic [7:0]               porta_pins    = 8'hff;
    wdt_wake_pkg::wake_out_t  wake_out;
    wdt_wake_pkg::clk_ctl_t   clk_ctl;
    logic                     wdt_running;
    logic [2:0]               low_speed_rc_osc_div      = 3'h0;
    logic [7:0]               exp_q[$];
    logic                     rd_seen       = 1'b0;
    int                       mismatches    = 0;
    int                       n_checks      = 0;
    int                       seed          = 15947;

    watchdog_and_wakeup_control DUT (
        .clk(clk), .resetn(resetn), .reg_req(reg_req), .reg_rdata(reg_rdata), .cpu_event(cpu_event),
        .wdt_always_on(wdt_always_on), .int_req(int_req), .int_enable(int_enable), .stack_full(stack_full),
        .low_speed_rc_osc_clk(low_speed_rc_osc_clk), .porta_pins(porta_pins), .wake_out(wake_out), .clk_ctl(clk_ctl),
        .wdt_running(wdt_running)
    );

    always #5 clk = ~clk;

    // slow oscillator at one eighth of clk keeps the 2^8 timeout near 2048 cycles
    always @(posedge clk) begin
        low_speed_rc_osc_div <= low_speed_rc_osc_div + 3'h1;
        low_speed_rc_osc_clk <= low_speed_rc_osc_div[2];
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] want);
        n_checks++;
        if (seen !== want) begin
            mismatches++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask : check

    // an empty queue yields a value no result carries, so a stray pulse fails
    function automatic logic [7:0] next_exp();
        return exp_q.size() > 0 ? exp_q.pop_front() : 8'hee;
    endfunction : next_exp

    always @(negedge clk) begin
        if (rd_seen)
            check(reg_rdata, next_exp());
        rd_seen = reg_req.rd;
        if (wake_out != '0)
            check({3'h0, wake_out}, next_exp());
    end

    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        reg_req.wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [2:0] a, input logic [7:0] want);
        exp_q.push_back(want);
        @(posedge clk);
        reg_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        reg_req.rd <= 1'b0;
    endtask : rd

    task automatic evt(input logic h, input logic c);
        @(posedge clk);
        cpu_event <= '{halt: h, clear_watchdog_instruction: c};
        @(posedge clk);
        cpu_event <= '0;
    endtask : evt

    task automatic wait_pulse(input int n, output int cnt);
        for (cnt = 0; cnt < n && wake_out == '0; cnt++)
            @(negedge clk);
        check({7'h0, cnt < n}, 8'h01);
        @(posedge clk);
    endtask : wait_pulse

    task automatic stop_test;
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : stop_test

    initial begin
        #200000;
        mismatches++;
        stop_test();
    end

    initial begin
        logic [7:0] v;
        int         n;
        repeat (4) @(posedge clk);
        resetn <= 1'b1;
        for (int a = 0; a < 6; a++)
            rd(3'(a), a == 0 ? 8'h53 : 8'h00);
        wr(3'h1, 8'hff);
        rd(3'h1, 8'h86);
        for (int k = 0; k < 3; k++) begin
            v = 8'($random(seed));
            wr(3'h4, v);
            rd(3'h4, v);
        end
        // idle with clocks kept; a request pending at halt must not wake
        wr(3'h1, 8'h80);
        wr(3'h2, 8'h01);
        for (int k = 0; k < 3; k++) begin
            int_enable <= k == 1 ? 8'h00 : 8'h03;
            stack_full <= k == 2;
            int_req <= 8'h02;
            evt(1'b1, 1'b0);
            @(negedge clk);
            check({4'h0, clk_ctl}, 8'h0f);
            repeat (10) @(posedge clk);
            exp_q.push_back(k == 0 ? 8'h14 : 8'h18);
            int_req <= 8'h03;
            wait_pulse(20, n);
        end
        int_req <= 8'h00;
        rd(3'h3, 8'h01);
        evt(1'b0, 1'b1);
        rd(3'h3, 8'h00);
        // idle with clocks off, woken by an enabled port pin only
        wr(3'h1, 8'h00);
        wr(3'h4, 8'h04);
        evt(1'b1, 1'b0);
        @(negedge clk);
        check({4'h0, clk_ctl}, 8'h01);
        @(posedge clk);
        porta_pins <= 8'hfd;
        repeat (10) @(posedge clk);
        exp_q.push_back(8'h18);
        porta_pins <= 8'hf9;
        wait_pulse(20, n);
        porta_pins <= 8'hff;
        // shortest period: overflow asleep, then overflow while running
        wr(3'h0, 8'h50);
        exp_q.push_back(8'h11);
        evt(1'b1, 1'b0);
        wait_pulse(3000, n);
        rd(3'h3, 8'h03);
        evt(1'b0, 1'b1);
        exp_q.push_back(8'h02);
        wait_pulse(3000, n);
        check({7'h0, n > 2030 && n < 2070}, 8'h01);
        rd(3'h3, 8'h02);
        wr(3'h0, 8'hab);
        @(negedge clk);
        check({7'h0, wdt_running}, 8'h00);
        @(posedge clk);
        wdt_always_on <= 1'b1;
        @(negedge clk);
        check({7'h0, wdt_running}, 8'h01);
        @(posedge clk);
        wdt_always_on <= 1'b0;
        // corrupted key forces a reset and sets the key flag
        exp_q.push_back(8'h02);
        wr(3'h0, 8'h03);
        wait_pulse(40, n);
        rd(3'h0, 8'h53);
        rd(3'h1, 8'h01);
        wr(3'h1, 8'h00);
        rd(3'h1, 8'h00);
        repeat (4) @(posedge clk);
        stop_test();
    end

endmodule : watchdog_and_wakeup_control_test

`default_nettype wire
